// ==== verilog/user_term_end.sv ====
// Purpose: framer core plus user terminal end of the link
// Assumes: bit timing taken from the network side tick
// Notes: core is shared with the network end via a parameter
// Function
// - eight bits per slot, numbered one to eight
// - thirty-two slots, 256 bits per frame
// - slot zero alternates alignment and other frame
// - non-alignment bit two always one
// - bit three carries far-end alarm
// - terminal sends spare bits as ones
// - terminal ignores received spare bits
// - bit one builds the check multiframe
// - sixteen frame multiframe, even frames aligned
// - check bits C1-C4 in even frames
// - error bit zero for errored block
// - class one link frames served first
// - interface always active, start request inert
// - multiframe pattern 001011, errors frames 13,15
// - two eight-frame check blocks
// - CRC x^4+x+1 over previous zeroed block
// - errored block clears error bit within second
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module frame_core
   import pri_frm_pkg::*;
#(
   parameter bit TERMINAL = 1'b1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic bit_en,
   input wire logic rx_line,
   output logic tx_line,
   output logic [4:0] tx_slot,
   output logic tx_take,
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte,
   output logic [4:0] rx_slot,
   output logic rx_valid,
   output logic in_frame,
   output logic mf_lock,
   output logic rai_rx,
   input wire logic [2:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata
);
   typedef struct packed {
      logic [2:0] tbit;
      logic [4:0] tslot;
      logic [3:0] tfrm;
      logic [7:0] tsh;
      logic tline;
      logic [3:0] tcrc;
      logic [3:0] trem;
      logic [1:0] epend;
      logic [2:0] rbit;
      logic [4:0] rslot;
      logic [3:0] rfrm;
      logic [6:0] rsh;
      rx_state_e rst;
      logic [1:0] miss;
      logic mflock;
      logic [5:0] mfsh;
      logic [3:0] rcrc;
      logic [3:0] rrem;
      logic [3:0] rcb;
      logic armed;
      logic prev;
      logic far_end_alarm_indication;
      logic [4:0] rspare;
      logic [7:0] rbyte;
      logic [4:0] rbslot;
      logic rvalid;
      logic alarm;
      logic [4:0] txsp;
      logic [15:0] crc_cnt;
      logic [15:0] far_cnt;
      logic [15:0] rdata;
   } core_s;

   core_s s, n;
   logic [7:0] cur, ts0, win;
   logic si, zero, crc_ev, far_ev, e_use, rb;

   // serial crc step, remainder of data times x^4
   function automatic logic [3:0] crc_step(input logic [3:0] r,
                                           input logic d);
      logic fb;
      fb = d ^ r[3];
      crc_step = {r[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
   endfunction

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      n = s;
      cur = s.tsh;
      ts0 = 8'h00;
      si = 1'b0;
      zero = 1'b0;
      crc_ev = 1'b0;
      far_ev = 1'b0;
      e_use = 1'b0;
      rb = 1'b0;
      win = {s.rsh, rx_line};
      n.rvalid = 1'b0;
      n.rdata = 16'h0000;
      // slot zero overhead byte for the frame now starting
      if (!s.tfrm[0]) begin
         si = s.trem[~s.tfrm[2:1]];
         ts0 = {si, FAS_PAT};
      end else begin
         if (s.tfrm == E_FRM_A || s.tfrm == E_FRM_B) begin
            si = (s.epend == 2'h0);
            e_use = !si;
         end else begin
            si = MFAS_PAT[3'(MFAS_TOP - s.tfrm[3:1])];
         end
         ts0 = {si, 1'b1, s.alarm,
                TERMINAL ? SPARE_ONES : s.txsp};
      end
      // transmit: load a byte at bit one, msb first
      if (bit_en) begin
         if (s.tbit == 3'h0) begin
            cur = (s.tslot == TS0) ? ts0 : tx_byte;
         end
         n.tline = cur[7];
         n.tsh = {cur[6:0], 1'b0};
         zero = (s.tbit == 3'h0) && (s.tslot == TS0) && !s.tfrm[0];
         n.tcrc = crc_step(s.tcrc, cur[7] & !zero);
         n.tbit = s.tbit + 3'h1;
         if (s.tbit == LAST_BIT) begin
            n.tslot = s.tslot + 5'h1;
            if (s.tslot == LAST_SLOT) begin
               n.tfrm = s.tfrm + 4'h1;
               if (s.tfrm[2:0] == BLK_LAST) begin
                  n.trem = n.tcrc;
                  n.tcrc = 4'h0;
               end
            end
         end
      end
      // receive: counters track the bit just taken
      if (bit_en) begin
         rb = rx_line & !((s.rbit == 3'h0) && (s.rslot == TS0)
                          && !s.rfrm[0]);
         n.rsh = win[6:0];
         n.rcrc = crc_step(s.rcrc, rb);
         n.rbit = s.rbit + 3'h1;
         if (s.rbit == LAST_BIT) begin
            n.rslot = s.rslot + 5'h1;
            if (s.rslot == LAST_SLOT) begin
               n.rfrm = s.rfrm + 4'h1;
               if (s.rfrm[2:0] == BLK_LAST) begin
                  n.rcrc = 4'h0;
                  n.rrem = crc_step(s.rcrc, rb);
                  crc_ev = s.armed && s.prev
                           && (s.rcb != s.rrem);
                  n.prev = s.armed;
                  n.armed = s.mflock;
               end
            end
            if (s.rst == SYNC) begin
               n.rbyte = win;
               n.rbslot = s.rslot;
               n.rvalid = 1'b1;
            end
         end
         unique case (s.rst)
            HUNT: begin
               if (win[6:0] == FAS_PAT) begin
                  n.rbit = 3'h0;
                  n.rslot = 5'h01;
                  n.rfrm = 4'h0;
                  n.rst = CHECK;
               end
            end
            CHECK: begin
               if (s.rslot == TS0 && s.rfrm[0] && s.rbit == CB_BIT
                   && !rx_line) begin
                  n.rst = HUNT;
               end
               if (s.rslot == TS0 && !s.rfrm[0]
                   && s.rbit == LAST_BIT) begin
                  n.rst = (win[6:0] == FAS_PAT) ? SYNC : HUNT;
                  n.miss = 2'h0;
               end
            end
            SYNC: begin
               if (s.rslot == TS0 && !s.rfrm[0]
                   && s.rbit == LAST_BIT) begin
                  n.miss = (win[6:0] == FAS_PAT) ? 2'h0
                                                 : s.miss + 2'h1;
                  if (n.miss == LOSS_LIMIT) begin
                     n.rst = HUNT;
                  end
               end
               if (s.rslot == TS0 && !s.rfrm[0] && s.rbit == 3'h0) begin
                  n.rcb[~s.rfrm[2:1]] = rx_line;
               end
               if (s.rslot == TS0 && s.rfrm[0]) begin
                  if (s.rbit == 3'h0) begin
                     n.mfsh = {s.mfsh[4:0], rx_line};
                     if (!s.mflock) begin
                        if (n.mfsh == MFAS_PAT) begin
                           n.mflock = 1'b1;
                           n.rfrm = MFAS_LAST_FRM;
                        end
                     end else if (s.rfrm == E_FRM_A
                                  || s.rfrm == E_FRM_B) begin
                        far_ev = !rx_line;
                     end else if (rx_line != MFAS_PAT[3'(MFAS_TOP
                                  - s.rfrm[3:1])]) begin
                        n.mflock = 1'b0;
                        n.armed = 1'b0;
                        n.prev = 1'b0;
                     end
                  end
                  if (s.rbit == ALARM_BIT) begin
                     n.far_end_alarm_indication = rx_line;
                  end
                  if (s.rbit == LAST_BIT && !TERMINAL) begin
                     n.rspare = win[4:0];
                  end
               end
            end
            default: n.rst = HUNT;
         endcase
         if (n.rst != SYNC) begin
            n.mflock = 1'b0;
            n.armed = 1'b0;
            n.prev = 1'b0;
            n.far_end_alarm_indication = 1'b0;
         end
      end
      // pending error bits, an arrival and a send in one cycle cancel
      if (crc_ev && !(bit_en && s.tbit == 3'h0 && s.tslot == TS0
                      && e_use)) begin
         n.epend = (s.epend == EPEND_MAX) ? s.epend : s.epend + 2'h1;
      end else if (!crc_ev && bit_en && s.tbit == 3'h0
                   && s.tslot == TS0 && e_use) begin
         n.epend = s.epend - 2'h1;
      end
      // register writes; a clear in the cycle of a counted event restarts the count at one
      if (reg_wr && reg_addr == REG_CTRL) begin
         n.alarm = reg_wdata[CTRL_ALARM];
      end
      if (reg_wr && reg_addr == REG_TX_SPARE && !TERMINAL) begin
         n.txsp = reg_wdata[4:0];
      end
      if (reg_wr && reg_addr == REG_CRC_ERR) begin
         n.crc_cnt = {15'h0000, crc_ev};
      end else if (crc_ev && s.crc_cnt != CNT_MAX) begin
         n.crc_cnt = s.crc_cnt + 16'h0001;
      end
      if (reg_wr && reg_addr == REG_FAR_ERR) begin
         n.far_cnt = {15'h0000, far_ev};
      end else if (far_ev && s.far_cnt != CNT_MAX) begin
         n.far_cnt = s.far_cnt + 16'h0001;
      end
      // read data valid in the following cycle only
      if (reg_rd) begin
         case (reg_addr)
            REG_CTRL: n.rdata = {15'h0000, s.alarm};
            REG_TX_SPARE: n.rdata = {11'h000,
                                     TERMINAL ? SPARE_ONES : s.txsp};
            REG_STATUS: n.rdata = {8'h00, s.rspare, s.far_end_alarm_indication,
                                   s.mflock, s.rst == SYNC};
            REG_CRC_ERR: n.rdata = s.crc_cnt;
            REG_FAR_ERR: n.rdata = s.far_cnt;
            default: n.rdata = 16'h0000;
         endcase
      end
   end

   // ***************************************************
   // state register
   // ***************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
         s.tline <= 1'b1;
         s.rst <= HUNT;
         s.rspare <= SPARE_ONES;
         s.txsp <= SPARE_ONES;
      end else begin
         s <= n;
      end
   end

   // tx_take is combinational, in_frame decodes the state flops, all other outputs from flops
   assign tx_slot = s.tslot;
   assign tx_take = bit_en && (s.tbit == 3'h0) && (s.tslot != TS0);
   assign tx_line = s.tline;
   assign rx_byte = s.rbyte;
   assign rx_slot = s.rbslot;
   assign rx_valid = s.rvalid;
   assign in_frame = (s.rst == SYNC);
   assign mf_lock = s.mflock;
   assign rai_rx = s.far_end_alarm_indication;
   assign reg_rdata = s.rdata;
endmodule

module user_term_end
   import pri_frm_pkg::*;
(
   input wire logic MCLK,
   input wire logic NRST,
   pri_link_if.user_end LINK,
   input wire logic [2:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [15:0] REG_RDATA,
   output logic [4:0] TX_SLOT,
   output logic TX_TAKE,
   input wire logic [7:0] TX_BYTE,
   input wire logic D_HI_VALID,
   input wire logic [7:0] D_HI_BYTE,
   output logic D_HI_TAKE,
   input wire logic D_LO_VALID,
   input wire logic [7:0] D_LO_BYTE,
   output logic D_LO_TAKE,
   output logic [7:0] RX_BYTE,
   output logic [4:0] RX_SLOT,
   output logic RX_VALID,
   output logic IN_FRAME,
   output logic MF_LOCK,
   output logic FAR_ALARM,
   input wire logic LAYER_ONE_START_REQ,
   output logic LAYER_ONE_CONFIRM
);
   typedef struct packed {
      logic confirm;
   } term_s;

   term_s s, n;
   logic take;
   logic [4:0] slot;
   logic [7:0] byte_out;

   // ***************************************************
   // d-channel priority and start handling
   // ***************************************************
   // class one link frames always win the d-channel slot
   always_comb begin
      n = s;
      n.confirm = LAYER_ONE_START_REQ;
      byte_out = TX_BYTE;
      if (slot == DCH_SLOT) begin
         byte_out = D_HI_VALID ? D_HI_BYTE :
                    (D_LO_VALID ? D_LO_BYTE : IDLE_FLAG);
      end
   end

   // start request only echoes; the link never sleeps
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign LAYER_ONE_CONFIRM = s.confirm;
   assign TX_SLOT = slot;
   assign TX_TAKE = take && (slot != DCH_SLOT);
   assign D_HI_TAKE = take && (slot == DCH_SLOT) && D_HI_VALID;
   assign D_LO_TAKE = take && (slot == DCH_SLOT) && !D_HI_VALID
                      && D_LO_VALID;

   frame_core #(.TERMINAL(1'b1)) core (
      .clk(MCLK),
      .nrst(NRST),
      .bit_en(LINK.bit_tick),
      .rx_line(LINK.nt_line),
      .tx_line(LINK.te_line),
      .tx_slot(slot),
      .tx_take(take),
      .tx_byte(byte_out),
      .rx_byte(RX_BYTE),
      .rx_slot(RX_SLOT),
      .rx_valid(RX_VALID),
      .in_frame(IN_FRAME),
      .mf_lock(MF_LOCK),
      .rai_rx(FAR_ALARM),
      .reg_addr(REG_ADDR),
      .reg_wdata(REG_WDATA),
      .reg_wr(REG_WR),
      .reg_rd(REG_RD),
      .reg_rdata(REG_RDATA)
   );
endmodule
`default_nettype wire

// ==== verilog/pri_frm_pkg.sv ====
// Purpose: shared constants for the primary rate framer ends
// Assumes: 50 MHz system clock, 2048 kbit/s line rate
// Notes: register map and frame layout live here only
package pri_frm_pkg;
   // ***************************************************
   // frame layout
   // ***************************************************
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [4:0] LAST_SLOT = 5'h1f;
   localparam logic [4:0] TS0 = 5'h00;
   localparam logic [4:0] DCH_SLOT = 5'h10;
   localparam logic [2:0] BLK_LAST = 3'h7;
   localparam logic [2:0] CB_BIT = 3'h1;
   localparam logic [2:0] ALARM_BIT = 3'h2;
   localparam logic [6:0] FAS_PAT = 7'h1b;
   localparam logic [5:0] MFAS_PAT = 6'h0b;
   localparam logic [2:0] MFAS_TOP = 3'h5;
   localparam logic [3:0] MFAS_LAST_FRM = 4'hb;
   localparam logic [3:0] E_FRM_A = 4'hd;
   localparam logic [3:0] E_FRM_B = 4'hf;
   localparam logic [3:0] CRC_POLY = 4'h3;
   localparam logic [4:0] SPARE_ONES = 5'h1f;
   localparam logic [7:0] IDLE_FLAG = 8'h7e;
   localparam logic [1:0] LOSS_LIMIT = 2'h3;
   localparam logic [1:0] EPEND_MAX = 2'h3;
   // ***************************************************
   // timing
   // ***************************************************
   localparam logic [15:0] CLK_KHZ = 16'hc350;
   localparam logic [15:0] BIT_KBPS = 16'h0800;
   // ***************************************************
   // register map
   // ***************************************************
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_TX_SPARE = 3'h1;
   localparam logic [2:0] REG_STATUS = 3'h2;
   localparam logic [2:0] REG_CRC_ERR = 3'h3;
   localparam logic [2:0] REG_FAR_ERR = 3'h4;
   localparam int CTRL_ALARM = 0;
   localparam int ST_INFRAME = 0;
   localparam int ST_MFLOCK = 1;
   localparam int ST_RAI = 2;
   localparam int ST_SPARE = 3;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   // receiver alignment states, gray along hunt-check-sync
   typedef enum logic [1:0] {
      HUNT = 2'h0,
      CHECK = 2'h1,
      SYNC = 2'h3
   } rx_state_e;
endpackage

// ==== verilog/pri_link_if.sv ====
// Purpose: serial link between user terminal and network termination
// Assumes: both ends on MCLK; bit_tick marks each line bit
// Notes: network side owns the bit timing
`timescale 1ns/1ps
`default_nettype none
interface pri_link_if;
   logic bit_tick;
   logic te_line;
   logic nt_line;
   modport user_end(input bit_tick, input nt_line, output te_line);
   modport net_end(output bit_tick, output nt_line, input te_line);
endinterface
`default_nettype wire

// ==== verilog/net_term_end.sv ====
// Purpose: network termination end of the primary rate link
// Assumes: user terminal end compiled first, sharing its core
// Notes: bit tick is an exact fractional divider of MCLK
`timescale 1ns/1ps
`default_nettype none
module net_term_end
   import pri_frm_pkg::*;
(
   input wire logic MCLK,
   input wire logic NRST,
   pri_link_if.net_end LINK,
   input wire logic [2:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [15:0] REG_RDATA,
   output logic [4:0] TX_SLOT,
   output logic TX_TAKE,
   input wire logic [7:0] TX_BYTE,
   output logic [7:0] RX_BYTE,
   output logic [4:0] RX_SLOT,
   output logic RX_VALID,
   output logic IN_FRAME,
   output logic MF_LOCK,
   output logic FAR_ALARM,
   input wire logic LOOP_INVOKE_REQ,
   input wire logic LOOP_RELEASE_REQ,
   output logic LOOP_ACTIVE
);
   typedef struct packed {
      logic [15:0] phase;
      logic tick;
      logic loop;
   } net_s;

   net_s s, n;
   logic [16:0] sum;

   // ***************************************************
   // bit rate divider and loopback state
   // ***************************************************
   // phase accumulator keeps the long-run rate exact, at the
   // cost of one clock of jitter between ticks
   always_comb begin
      n = s;
      sum = {1'b0, s.phase} + {1'b0, BIT_KBPS};
      n.tick = 1'b0;
      n.phase = sum[15:0];
      if (sum >= {1'b0, CLK_KHZ}) begin
         n.phase = 16'(sum - {1'b0, CLK_KHZ});
         n.tick = 1'b1;
      end
      // invoke wins when both requests arrive together
      if (LOOP_INVOKE_REQ) begin
         n.loop = 1'b1;
      end else if (LOOP_RELEASE_REQ) begin
         n.loop = 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign LINK.bit_tick = s.tick;
   assign LOOP_ACTIVE = s.loop;

   frame_core #(.TERMINAL(1'b0)) core (
      .clk(MCLK),
      .nrst(NRST),
      .bit_en(s.tick),
      .rx_line(LINK.te_line),
      .tx_line(LINK.nt_line),
      .tx_slot(TX_SLOT),
      .tx_take(TX_TAKE),
      .tx_byte(TX_BYTE),
      .rx_byte(RX_BYTE),
      .rx_slot(RX_SLOT),
      .rx_valid(RX_VALID),
      .in_frame(IN_FRAME),
      .mf_lock(MF_LOCK),
      .rai_rx(FAR_ALARM),
      .reg_addr(REG_ADDR),
      .reg_wdata(REG_WDATA),
      .reg_wr(REG_WR),
      .reg_rd(REG_RD),
      .reg_rdata(REG_RDATA)
   );
endmodule
`default_nettype wire

// ==== verif/pri_frm_assertions.sv ====
// Purpose: wire checks on the primary rate link between both ends
// Assumes: both ends leave reset together, transmitting frame 0 first
// Notes: frame phase is counted from reset, not hunted, to stay small
`timescale 1ns/1ps
`default_nettype none
module pri_frm_assertions
   import pri_frm_pkg::*;
(
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic bit_tick,
   input wire logic te_line,
   input wire logic nt_line
);
   typedef struct packed {
      logic [7:0] pos;
      logic [3:0] frm;
      logic [3:0] crc;
      logic [3:0] last;
      logic go;
      logic ok;
   } trk_s;
   trk_s q_r, q_nxt;
   logic d;
   // *********************************************
   // phase tracker and block remainder
   // *********************************************
   // check bit places count as zero so own check bits cannot feed back
   always_comb begin
      q_nxt = q_r;
      d = te_line & ~(q_r.pos == 8'h00 & ~q_r.frm[0]);
      if (bit_tick) begin
         q_nxt.pos = q_r.pos + 8'h01;
         if (q_r.pos == 8'hff) q_nxt.frm = q_r.frm + 4'h1;
         q_nxt.crc = {q_r.crc[2:0], 1'b0} ^ ((q_r.crc[3] ^ d) ? CRC_POLY : 4'h0);
         if (q_r.pos == 8'hff && q_r.frm[2:0] == BLK_LAST) begin
            q_nxt.last = q_nxt.crc;
            q_nxt.crc = 4'h0;
            q_nxt.ok = q_r.go; // first pass only discards reset level
            q_nxt.go = 1'b1;
         end
      end
   end
   // starts one bit before frame 0 bit one
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) q_r <= '{pos: 8'hff, frm: 4'hf, default: '0};
      else q_r <= q_nxt;
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!NRST);
   chk_tick_gap_quiet: assert property (bit_tick |=> !bit_tick [*8])
      else $error("bit ticks too close");
   chk_tick_rate: assert property (bit_tick |-> ##[24:25] bit_tick)
      else $error("bit tick spacing off");
   chk_te_bit_hold: assert property ($changed(te_line) |-> $past(bit_tick))
      else $error("te line moved between ticks");
   chk_nt_bit_hold: assert property ($changed(nt_line) |-> $past(bit_tick))
      else $error("nt line moved between ticks");
   chk_align_word: assert property (bit_tick && !q_r.frm[0] && q_r.pos inside {[8'h01:8'h07]} |->
      te_line == FAS_PAT[3'h7 - q_r.pos[2:0]] && nt_line == FAS_PAT[3'h7 - q_r.pos[2:0]])
      else $error("alignment word wrong");
   chk_fixed_one: assert property (bit_tick && q_r.frm[0] && q_r.pos == 8'h01 |-> te_line && nt_line)
      else $error("fixed bit not one");
   chk_spare_ones: assert property (bit_tick && q_r.frm[0] && q_r.pos inside {[8'h03:8'h07]} |-> te_line)
      else $error("terminal spare bit not one");
   chk_mf_word: assert property (bit_tick && q_r.frm[0] && q_r.pos == 8'h00 && q_r.frm <= MFAS_LAST_FRM |->
      te_line == MFAS_PAT[3'h5 - q_r.frm[3:1]] && nt_line == MFAS_PAT[3'h5 - q_r.frm[3:1]])
      else $error("multiframe word wrong");
   chk_check_bits: assert property (bit_tick && q_r.ok && !q_r.frm[0] && q_r.pos == 8'h00 |->
      te_line == q_r.last[2'h3 - q_r.frm[2:1]])
      else $error("check bit wrong");
endmodule
`default_nettype wire

// ==== verif/primary_rate_crc4_framer_bench.sv ====
// Purpose: end to end bench for terminal and network framer ends
// Assumes: slot bytes are random every cycle, model keeps taken ones
// Notes: run is about fourteen frames, too short to see every count
`timescale 1ns/1ps
`default_nettype none
module primary_rate_crc4_framer_bench;
   import pri_frm_pkg::*;
   logic mclk, nrst, uwr, urd, nwr, nrd, utake, ntake, uv, nv, uif, nif;
   logic ufa, nfa, hv, lv, htk, ltk, start, conf, linv, lrel, lact;
   logic [2:0] ua, na;
   logic [15:0] uw, nw, ur, nr;
   logic [4:0] uslot, nslot, urs, nrs;
   logic [7:0] ub, nb, urb, nrb, hb, lb;
   logic [7:0] exp_u [32];
   logic [7:0] exp_n [32];
   bit has_u [32];
   bit has_n [32];
   int failures, checked, k;
   logic [31:0] seed = 32'h0000e31c;
   pri_link_if pri_link_if_i();
   user_term_end user_term_end_i(.MCLK(mclk), .NRST(nrst), .LINK(pri_link_if_i),
      .REG_ADDR(ua), .REG_WDATA(uw), .REG_WR(uwr), .REG_RD(urd), .REG_RDATA(ur),
      .TX_SLOT(uslot), .TX_TAKE(utake), .TX_BYTE(ub), .D_HI_VALID(hv),
      .D_HI_BYTE(hb), .D_HI_TAKE(htk), .D_LO_VALID(lv), .D_LO_BYTE(lb),
      .D_LO_TAKE(ltk), .RX_BYTE(urb), .RX_SLOT(urs), .RX_VALID(uv),
      .IN_FRAME(uif), .MF_LOCK(), .FAR_ALARM(ufa),
      .LAYER_ONE_START_REQ(start), .LAYER_ONE_CONFIRM(conf));
   net_term_end net_term_end_i(.MCLK(mclk), .NRST(nrst), .LINK(pri_link_if_i),
      .REG_ADDR(na), .REG_WDATA(nw), .REG_WR(nwr), .REG_RD(nrd), .REG_RDATA(nr),
      .TX_SLOT(nslot), .TX_TAKE(ntake), .TX_BYTE(nb), .RX_BYTE(nrb),
      .RX_SLOT(nrs), .RX_VALID(nv), .IN_FRAME(nif), .MF_LOCK(), .FAR_ALARM(nfa),
      .LOOP_INVOKE_REQ(linv), .LOOP_RELEASE_REQ(lrel), .LOOP_ACTIVE(lact));
   pri_frm_assertions pri_frm_assertions_i(.MCLK(mclk), .NRST(nrst),
      .bit_tick(pri_link_if_i.bit_tick), .te_line(pri_link_if_i.te_line),
      .nt_line(pri_link_if_i.nt_line));
   // *********************************************
   // helpers
   // *********************************************
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic close_out();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one strobe cycle; read data land in the following cycle only
   task automatic reg_op(input bit net, input bit wr, input logic [2:0] a,
      input logic [15:0] d);
      @(posedge mclk);
      if (net) {na, nw, nwr, nrd} <= {a, d, wr, !wr};
      else {ua, uw, uwr, urd} <= {a, d, wr, !wr};
      @(posedge mclk);
      {uwr, urd, nwr, nrd} <= 4'h0;
      #1;
   endtask
   task automatic rd(input bit net, input logic [2:0] a, input logic [15:0] e,
      input logic [15:0] m);
      reg_op(net, 1'b0, a, 16'h0000);
      chk((net ? nr : ur) & m, e);
   endtask
   // counts line bits; a stalled tick ends the run
   task automatic ticks(input int n);
      k = 0;
      while (n > 0 && k < 30) begin
         @(posedge mclk);
         #1;
         k++;
         if (pri_link_if_i.bit_tick === 1'b1) begin
            n--;
            k = 0;
         end
      end
      if (n > 0) begin
         failures++;
         close_out();
      end
   endtask
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // *********************************************
   // stimulus and slot model
   // *********************************************
   // one D source always valid, so slot 16 always has an expectation
   always @(posedge mclk) begin
      {ub, nb, hb, lb} <= rnd();
      hv <= seed[0];
      lv <= seed[1] | ~seed[0];
   end
   // sampled mid-cycle, clear of the edge that moves the outputs
   always @(negedge mclk) begin
      if (utake === 1'b1) {exp_u[uslot], has_u[uslot]} = {ub, 1'b1};
      if (htk === 1'b1 || ltk === 1'b1) {exp_u[16], has_u[16]} = {htk ? hb : lb, 1'b1};
      if (ntake === 1'b1) {exp_n[nslot], has_n[nslot]} = {nb, 1'b1};
      if (ltk === 1'b1) chk({15'h0000, hv}, 16'h0000);
      if (nv === 1'b1 && nrs != TS0 && has_u[nrs]) chk({8'h00, nrb}, {8'h00, exp_u[nrs]});
      if (uv === 1'b1 && urs != TS0 && has_n[urs]) chk({8'h00, urb}, {8'h00, exp_n[urs]});
   end
   initial begin
      {nrst, uwr, urd, nwr, nrd, start, linv, lrel, hv, lv} = '0;
      {ua, na, uw, nw, ub, nb, hb, lb, failures, checked} = '0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      rd(0, REG_STATUS, 16'h00f8, 16'hffff);
      reg_op(0, 1, REG_TX_SPARE, 16'h0000);
      rd(0, REG_TX_SPARE, 16'h001f, 16'hffff);
      rd(0, 3'h5, 16'h0000, 16'hffff);
      reg_op(1, 1, REG_TX_SPARE, 16'h000a);
      for (k = 0; k < 40000 && !(uif === 1'b1 && nif === 1'b1); k++) @(posedge mclk);
      chk({14'h0000, uif, nif}, 16'h0003);
      // no alignment within the bound: stop here, already counted
      if (!(uif === 1'b1 && nif === 1'b1)) close_out();
      ticks(512);
      rd(0, REG_STATUS, 16'h00f9, 16'hfffd);
      rd(1, REG_STATUS, 16'h00f9, 16'hfffd);
      reg_op(0, 1, REG_CTRL, 16'h0001);
      reg_op(1, 1, REG_CTRL, 16'h0001);
      ticks(512);
      chk({14'h0000, ufa, nfa}, 16'h0003);
      rd(1, REG_STATUS, 16'h0005, 16'h0005);
      reg_op(0, 1, REG_CTRL, 16'h0000);
      reg_op(1, 1, REG_CTRL, 16'h0000);
      ticks(512);
      chk({14'h0000, ufa, nfa}, 16'h0000);
      @(posedge mclk) start <= 1'b1;
      @(posedge mclk) start <= 1'b0;
      #1 chk({14'h0000, conf, uif}, 16'h0003);
      @(posedge mclk) linv <= 1'b1;
      @(posedge mclk) linv <= 1'b0;
      #1 chk({15'h0000, conf}, 16'h0000);
      @(posedge mclk) lrel <= 1'b0;
      #1 chk({15'h0000, lact}, 16'h0001);
      @(posedge mclk) lrel <= 1'b1;
      @(posedge mclk) lrel <= 1'b0;
      @(posedge mclk) #1 chk({15'h0000, lact}, 16'h0000);
      ticks(1536);
      rd(0, REG_CRC_ERR, 16'h0000, 16'hffff);
      rd(1, REG_CRC_ERR, 16'h0000, 16'hffff);
      rd(0, REG_FAR_ERR, 16'h0000, 16'hffff);
      rd(1, REG_FAR_ERR, 16'h0000, 16'hffff);
      close_out();
   end
endmodule
`default_nettype wire
